/* rtl/sdm_pkg.sv */
// constants and types for the sense-mux and state controller
// assumes a 250 MHz core clock and an Avalon-MM register slave
package sdm_pkg;
    // clock period in nanoseconds
    localparam int CLK_PERIOD_NS = 4;
    // standby delay time in microseconds, plain default
    localparam int STANDBY_DELAY_TIME_US = 1000;
    localparam int STANDBY_DELAY_CYCLES = (STANDBY_DELAY_TIME_US * 1000) / CLK_PERIOD_NS;
    // retry timer in microseconds, plain default
    localparam int RETRY_TIME_US = 1000;
    localparam int RETRY_CYCLES = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;
    // sense settle time in microseconds, plain default
    localparam int SENSE_SETTLE_TIME_US = 10;
    localparam int SENSE_SETTLE_CYCLES = (SENSE_SETTLE_TIME_US * 1000) / CLK_PERIOD_NS;

    // register word addresses (byte address / 4)
    localparam logic [1:0] ADDR_STATUS  = 2'h0;
    localparam logic [1:0] ADDR_IRQ     = 2'h1;
    localparam logic [1:0] ADDR_MASK    = 2'h2;
    localparam logic [1:0] ADDR_CONTROL = 2'h3;

    // interrupt event bit positions
    localparam int EV_FAULT_ENTER = 0;
    localparam int EV_FAULT_EXIT  = 1;
    localparam int EV_OFF_FAULT   = 2;
    localparam int EV_STANDBY     = 3;
    localparam int NUM_EV         = 4;

    // control register bit positions
    localparam int CTL_LATCH_BIT  = 0;

    // reset values
    localparam logic [3:0] MASK_RESET = 4'h0;

    // sense output selection
    typedef enum logic [1:0] {
        SDM_SNS_HIGHZ,
        SDM_SNS_CURRENT,
        SDM_SNS_TEMP,
        SDM_SNS_FAULT
    } sdm_sense_t;

    // operating states
    typedef enum logic [2:0] {
        SDM_ST_STBY_DELAY,
        SDM_ST_STANDBY,
        SDM_ST_DIAG,
        SDM_ST_ACTIVE,
        SDM_ST_FAULT
    } sdm_state_t;
endpackage

/* rtl/sdm_ctrl.sv */
// sense multiplexer and operating state sequencer of a one-channel power switch
// assumes all pins synchronous to clk; analog fault detectors give levels
`timescale 1ns/1ns
`default_nettype none

module sdm_ctrl #(
    parameter int STBY_CYCLES   = sdm_pkg::STANDBY_DELAY_CYCLES,
    parameter int RETRY_CYC     = sdm_pkg::RETRY_CYCLES,
    parameter int SETTLE_CYC    = sdm_pkg::SENSE_SETTLE_CYCLES
) (
    // clock, reset, clock enable
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    // control pins from the controller
    input  wire logic        enable,
    input  wire logic        diagnostic_enable,
    input  wire logic        sense_select,
    input  wire logic        latchPin,
    // fault detector levels from the analog side
    input  wire logic        thermalShutdown,
    input  wire logic        currentLimit,
    input  wire logic        offStateAbove,
    // switch and sense output control
    output logic             switchOn,
    output logic             lowPower,
    output logic             offDetectOn,
    output sdm_pkg::sdm_sense_t sense_output,
    output logic             sense_fault_level,
    output logic             senseSettled,
    // avalon-mm slave
    input  wire logic [1:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    output logic [31:0]      avsReadData,
    output logic             avsWaitRequest,
    // interrupt
    output logic             irq
);

    // state register and next state
    // the state alone decides switch and standby; the fault half of the mux also takes offFault_r
    sdm_pkg::sdm_state_t state_r;
    sdm_pkg::sdm_state_t state_nxt;
    // delayed pins for edge detection
    logic        enable_r;
    logic        diag_r;
    // standby delay, retry and sense settle counters
    logic [31:0] stbyCnt_r;
    logic [31:0] retryCnt_r;
    logic [31:0] settleCnt_r;
    // latched off-state fault indication
    // it follows the comparator while armed, so it clears once the level drops
    logic        offFault_r;
    // software latch override and registers
    // ack_r marks the second cycle of a bus request
    logic        swLatch_r;
    logic [sdm_pkg::NUM_EV-1:0] irqStat_r;
    logic [sdm_pkg::NUM_EV-1:0] irqMask_r;
    logic        ack_r;
    // derived terms
    logic        enRise;
    logic        diagRise;
    logic        diagFall;
    logic        shutdown;
    logic        faultDetect;
    logic        retryDone;
    logic        stbyDone;
    logic        latchEff;
    logic [sdm_pkg::NUM_EV-1:0] events;
    logic        rdStat;

    // edges of the control pins against last cycle's sample; history resets low,
    // the idle level of both pins, so no false edge follows reset
    assign enRise   = enable & ~enable_r;
    assign diagRise = diagnostic_enable & ~diag_r;
    assign diagFall = ~diagnostic_enable & diag_r;
    // thermal or current-limit shutdown
    // either detector forces the fault state from active
    assign shutdown = thermalShutdown | currentLimit;
    // timers end when the counter reaches its parameter, widened to 32 bits
    assign retryDone = (retryCnt_r == 32'(RETRY_CYC));
    assign stbyDone  = (stbyCnt_r == 32'(STBY_CYCLES));
    // either the pin or the control register keeps the fault state latched
    assign latchEff  = latchPin | swLatch_r;

    // off-state comparator only armed with diag high and enable low
    // standby keeps it off too, since no diagnostics run there
    assign offDetectOn = diagnostic_enable & ~enable & (state_r != sdm_pkg::SDM_ST_STANDBY);

    // fault detect combines waiting-for-retry and off-state fault
    // it steers the mux only; the switch itself follows the state
    assign faultDetect = (state_r == sdm_pkg::SDM_ST_FAULT) | offFault_r;

    // next-state logic
    // one edge from pin sample to new state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // standby or its delay: a shutdown on the wake edge goes straight to fault
            sdm_pkg::SDM_ST_STBY_DELAY, sdm_pkg::SDM_ST_STANDBY: begin
                if (shutdown && enable) begin
                    state_nxt = sdm_pkg::SDM_ST_FAULT;
                end else if (enable) begin
                    state_nxt = sdm_pkg::SDM_ST_ACTIVE;
                end else if (diagnostic_enable) begin
                    state_nxt = sdm_pkg::SDM_ST_DIAG;
                end else if (state_r == sdm_pkg::SDM_ST_STBY_DELAY && stbyDone) begin
                    state_nxt = sdm_pkg::SDM_ST_STANDBY;
                end
            end
            // diagnostic state: switch stays off until enable rises
            sdm_pkg::SDM_ST_DIAG: begin
                if (enable) begin
                    state_nxt = sdm_pkg::SDM_ST_ACTIVE;
                end else if (!diagnostic_enable) begin
                    state_nxt = sdm_pkg::SDM_ST_STBY_DELAY;
                end
            end
            // active: a shutdown wins over any pin change
            sdm_pkg::SDM_ST_ACTIVE: begin
                if (shutdown) begin
                    state_nxt = sdm_pkg::SDM_ST_FAULT;
                end else if (!enable && !diagnostic_enable) begin
                    state_nxt = sdm_pkg::SDM_ST_STBY_DELAY;
                end else if (!enable) begin
                    state_nxt = sdm_pkg::SDM_ST_DIAG;
                end
            end
            sdm_pkg::SDM_ST_FAULT: begin
                // exit needs faults gone, latch low and retry timer done
                if (!shutdown && !latchEff && retryDone) begin
                    if (enable) begin
                        state_nxt = sdm_pkg::SDM_ST_ACTIVE;
                    end else if (diagnostic_enable) begin
                        state_nxt = sdm_pkg::SDM_ST_DIAG;
                    end else begin
                        state_nxt = sdm_pkg::SDM_ST_STBY_DELAY;
                    end
                end
            end
            default: state_nxt = sdm_pkg::SDM_ST_STBY_DELAY;
        endcase
    end

    // state register
    // clkEn low holds every timer too, so all delays stretch with it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= sdm_pkg::SDM_ST_STBY_DELAY;
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    // pin history for edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable_r <= 1'b0;
            diag_r   <= 1'b0;
        end else if (clkEn) begin
            enable_r <= enable;
            diag_r   <= diagnostic_enable;
        end
    end

    // standby delay counter, runs only while both pins stay low
    // it stops at its end value so stbyDone stays true until the state moves on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stbyCnt_r <= 32'h0;
        end else if (clkEn) begin
            if (state_r != sdm_pkg::SDM_ST_STBY_DELAY || enable || diagnostic_enable) begin
                stbyCnt_r <= 32'h0;
            end else if (!stbyDone) begin
                stbyCnt_r <= stbyCnt_r + 32'h1;
            end
        end
    end

    // retry timer, starts on fault entry and saturates
    // saturation keeps retryDone set while a latch still holds the fault
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            retryCnt_r <= 32'h0;
        end else if (clkEn) begin
            if (state_r != sdm_pkg::SDM_ST_FAULT) begin
                retryCnt_r <= 32'h0;
            end else if (!retryDone) begin
                retryCnt_r <= retryCnt_r + 32'h1;
            end
        end
    end

    // sense settle counter after switch turn-on
    // the settled flag only helps the controller; the device never waits on it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            settleCnt_r <= 32'h0;
        end else if (clkEn) begin
            if (!switchOn) begin
                settleCnt_r <= 32'h0;
            end else if (settleCnt_r != 32'(SETTLE_CYC)) begin
                settleCnt_r <= settleCnt_r + 32'h1;
            end
        end
    end
    assign senseSettled = switchOn && (settleCnt_r == 32'(SETTLE_CYC));

    // off-state fault follows comparator; edges clear it
    // clear terms come first, so an edge beats a comparator level in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            offFault_r <= 1'b0;
        end else if (clkEn) begin
            if (diagFall || enRise || !offDetectOn) begin
                offFault_r <= 1'b0;
            end else begin
                offFault_r <= offStateAbove;
            end
        end
    end

    // switch and power outputs
    // switch conducts in active only, so diagnostic and fault keep it off
    assign switchOn = (state_r == sdm_pkg::SDM_ST_ACTIVE);
    assign lowPower = (state_r == sdm_pkg::SDM_ST_STANDBY);

    // sense multiplexer
    // standby shows high impedance even if diag rose this cycle
    // temperature outranks a fault: select high never shows the fault level
    always_comb begin
        if (!diagnostic_enable || state_r == sdm_pkg::SDM_ST_STANDBY) begin
            sense_output = sdm_pkg::SDM_SNS_HIGHZ;
        end else if (sense_select) begin
            sense_output = sdm_pkg::SDM_SNS_TEMP;
        end else if (faultDetect) begin
            sense_output = sdm_pkg::SDM_SNS_FAULT;
        end else begin
            sense_output = sdm_pkg::SDM_SNS_CURRENT;
        end
    end
    assign sense_fault_level = (sense_output == sdm_pkg::SDM_SNS_FAULT);

    // event sources for interrupts
    // entry and exit look one edge ahead through state_nxt
    // off fault is level held: it sets again after a clear while still present
    assign events[sdm_pkg::EV_FAULT_ENTER] = (state_nxt == sdm_pkg::SDM_ST_FAULT)
                                             && (state_r != sdm_pkg::SDM_ST_FAULT);
    assign events[sdm_pkg::EV_FAULT_EXIT]  = (state_r == sdm_pkg::SDM_ST_FAULT)
                                             && (state_nxt != sdm_pkg::SDM_ST_FAULT);
    assign events[sdm_pkg::EV_OFF_FAULT]   = offFault_r;
    assign events[sdm_pkg::EV_STANDBY]     = (state_nxt == sdm_pkg::SDM_ST_STANDBY)
                                             && (state_r != sdm_pkg::SDM_ST_STANDBY);

    // bus: one wait cycle, answer on second cycle
    // read data are captured at the end of the first cycle and stand through the accept edge
    // clkEn low also holds the acknowledge, which stretches the wait
    assign avsWaitRequest = (avsRead || avsWrite) && !ack_r;
    assign rdStat = avsRead && ack_r && (avsAddress == sdm_pkg::ADDR_IRQ);

    // acknowledge toggle
    // it drops after the accept edge, so back-to-back requests each wait once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else if (clkEn) begin
            ack_r <= (avsRead || avsWrite) && !ack_r;
        end
    end

    // sticky status per event; set wins over read-clear
    // a read clears only the bits that it returned, so an event that lands
    // between capture and accept stays pending for the next read
    for (genvar i = 0; i < sdm_pkg::NUM_EV; i++) begin : g_irq
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                irqStat_r[i] <= 1'b0;
            end else if (clkEn) begin
                if (events[i]) begin
                    irqStat_r[i] <= 1'b1;
                end else if (rdStat && avsReadData[i]) begin
                    irqStat_r[i] <= 1'b0;
                end
            end
        end
    end

    // mask and control writes
    // writes take effect at the accept edge only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqMask_r <= sdm_pkg::MASK_RESET;
            swLatch_r <= 1'b0;
        end else if (clkEn && avsWrite && ack_r) begin
            if (avsAddress == sdm_pkg::ADDR_MASK) begin
                irqMask_r <= avsWriteData[sdm_pkg::NUM_EV-1:0];
            end
            if (avsAddress == sdm_pkg::ADDR_CONTROL) begin
                swLatch_r <= avsWriteData[sdm_pkg::CTL_LATCH_BIT];
            end
        end
    end

    // read data register
    // status word: off fault, switch, state, bit 0 reserved as zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avsReadData <= 32'h0;
        end else if (clkEn && avsRead && !ack_r) begin
            case (avsAddress)
                sdm_pkg::ADDR_STATUS:  avsReadData <= {26'h0, offFault_r, switchOn, state_r, 1'b0};
                sdm_pkg::ADDR_IRQ:     avsReadData <= {28'h0, irqStat_r};
                sdm_pkg::ADDR_MASK:    avsReadData <= {28'h0, irqMask_r};
                sdm_pkg::ADDR_CONTROL: avsReadData <= {31'h0, swLatch_r};
                default:               avsReadData <= 32'h0;
            endcase
        end
    end

    // level interrupt
    // high while any unmasked status bit is set
    assign irq = |(irqStat_r & irqMask_r);

endmodule
`default_nettype wire

/* verif/sdm_ctrl_chk.sv */
// checker for the sense mux and state sequencer pins
// assumes one clock domain; bound to every sdm_ctrl instance
`timescale 1ns/1ns
`default_nettype none
module sdm_ctrl_chk #(
    parameter int STBY_CYCLES = 10,
    parameter int RETRY_CYC   = 10
) (
    // clock, reset, clock enable
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               clkEn,
    // control pins and fault detectors
    input wire logic               enable,
    input wire logic               diagnostic_enable,
    input wire logic               sense_select,
    input wire logic               latchPin,
    input wire logic               thermalShutdown,
    input wire logic               currentLimit,
    // switch and sense outputs
    input wire logic               switchOn,
    input wire logic               lowPower,
    input wire logic               offDetectOn,
    input var  sdm_pkg::sdm_sense_t sense_output,
    input wire logic               sense_fault_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles with both enables, the latch pin and both shutdown detectors low
    int idleCnt_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) idleCnt_r <= 0;
        else if (enable || diagnostic_enable || latchPin || thermalShutdown || currentLimit)
            idleCnt_r <= 0;
        else if (clkEn && idleCnt_r < 1000) idleCnt_r <= idleCnt_r + 1;
    end
    // shutdown seen while the switch conducts
    sequence s_shut;
        clkEn && switchOn && (thermalShutdown || currentLimit);
    endsequence
    // enable raised while resting in standby
    sequence s_wake;
        clkEn && lowPower && enable && !thermalShutdown && !currentLimit;
    endsequence
    property p_shut;
        s_shut |=> !switchOn && (sense_fault_level == (diagnostic_enable && !sense_select));
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown did not enter fault");
    property p_wake;
        s_wake |=> switchOn;
    endproperty
    a_wake: assert property (p_wake) else $error("enable did not wake switch");
    property p_hiz;
        (!diagnostic_enable || lowPower) |-> sense_output == sdm_pkg::SDM_SNS_HIGHZ;
    endproperty
    a_hiz: assert property (p_hiz) else $error("sense not high impedance");
    property p_temp;
        diagnostic_enable && sense_select && !lowPower |-> sense_output == sdm_pkg::SDM_SNS_TEMP;
    endproperty
    a_temp: assert property (p_temp) else $error("sense not temperature");
    property p_flag;
        sense_fault_level == (sense_output == sdm_pkg::SDM_SNS_FAULT);
    endproperty
    a_flag: assert property (p_flag) else $error("fault level flag wrong");
    property p_on_nofault;
        switchOn |-> sense_output != sdm_pkg::SDM_SNS_FAULT;
    endproperty
    a_on_nofault: assert property (p_on_nofault) else $error("fault shown while on");
    property p_offdet;
        offDetectOn |-> diagnostic_enable && !enable && !switchOn && !lowPower;
    endproperty
    a_offdet: assert property (p_offdet) else $error("off detect out of place");
    property p_stby;
        idleCnt_r == STBY_CYCLES + RETRY_CYC + 4 |-> lowPower;
    endproperty
    a_stby: assert property (p_stby) else $error("standby not reached");
endmodule
bind sdm_ctrl sdm_ctrl_chk #(.STBY_CYCLES(STBY_CYCLES), .RETRY_CYC(RETRY_CYC)) sdm_ctrl_chk_i (
    .clk(clk), .rstn(rstn), .clkEn(clkEn), .enable(enable),
    .diagnostic_enable(diagnostic_enable), .sense_select(sense_select), .latchPin(latchPin),
    .thermalShutdown(thermalShutdown), .currentLimit(currentLimit), .switchOn(switchOn),
    .lowPower(lowPower), .offDetectOn(offDetectOn), .sense_output(sense_output),
    .sense_fault_level(sense_fault_level));
`default_nettype wire

/* verif/sdm_mcu.sv */
// controller model: samples the sense output and keeps a median of three
// assumes the settled flag marks the end of the sense settling time
`timescale 1ns/1ns
`default_nettype none
module sdm_mcu (
    // clock and reset
    input wire logic               clk,
    input wire logic               rstn,
    // sense side of the switch
    input wire logic               senseSettled,
    input var  sdm_pkg::sdm_sense_t sense_output,
    // filtered reading
    output logic [1:0]             median
);
    logic [1:0] s0_r, s1_r, s2_r; // last three accepted samples
    // sample only once the sense output has settled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s0_r <= 2'h0;
            s1_r <= 2'h0;
            s2_r <= 2'h0;
        end else if (senseSettled) begin
            s0_r <= sense_output;
            s1_r <= s0_r;
            s2_r <= s1_r;
        end
    end
    // median rejects a single outlier sample
    assign median = (s0_r >= s1_r) ? ((s1_r >= s2_r) ? s1_r : ((s0_r >= s2_r) ? s2_r : s0_r))
                  : ((s0_r >= s2_r) ? s0_r : ((s1_r >= s2_r) ? s2_r : s1_r));
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for sdm_ctrl with an avalon master and a controller model
// assumes short timer parameters so the run stays brief
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int STBY = 10;
    localparam int RETRY = 10;
    localparam int SETTLE = 5;
    logic clk = 1'b0, rstn = 1'b0, clkEn = 1'b1;
    logic enable = 1'b0, diagnostic_enable = 1'b0, sense_select = 1'b0, latchPin = 1'b0;
    logic thermalShutdown = 1'b0, currentLimit = 1'b0, offStateAbove = 1'b0;
    logic avsRead = 1'b0, avsWrite = 1'b0, avsWaitRequest, irq;
    logic [1:0] avsAddress = 2'h0, median;
    logic [31:0] avsWriteData = 32'h0, avsReadData, rdata;
    logic switchOn, lowPower, offDetectOn, sense_fault_level, senseSettled;
    sdm_pkg::sdm_sense_t sense_output;
    int errors = 0, comparisons = 0, i;
    logic s, o;
    // free running clock
    always #2 clk = ~clk;
    sdm_ctrl #(.STBY_CYCLES(STBY), .RETRY_CYC(RETRY), .SETTLE_CYC(SETTLE)) sdm_ctrl_i (
        .clk(clk), .rstn(rstn), .clkEn(clkEn), .enable(enable),
        .diagnostic_enable(diagnostic_enable), .sense_select(sense_select),
        .latchPin(latchPin), .thermalShutdown(thermalShutdown), .currentLimit(currentLimit),
        .offStateAbove(offStateAbove), .switchOn(switchOn), .lowPower(lowPower),
        .offDetectOn(offDetectOn), .sense_output(sense_output),
        .sense_fault_level(sense_fault_level), .senseSettled(senseSettled),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .irq(irq));
    sdm_mcu sdm_mcu_i (.clk(clk), .rstn(rstn), .senseSettled(senseSettled),
        .sense_output(sense_output), .median(median));
    // reference mux from the pin levels and the fault condition
    function automatic logic [1:0] exp_sns(input logic dg, input logic sl, input logic f);
        return !dg ? 2'h0 : sl ? 2'h2 : f ? 2'h3 : 2'h1;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // launch just after a rising edge, whatever the caller's phase
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        // waitrequest and read data are taken at the same rising edge
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        if (n >= 50) chk("waitrequest", 0, 1);
        rdata = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #20000;
        errors++;
        final_report();
    end
    initial begin
        void'($urandom(71));
        cyc(5);
        rstn <= 1'b1;
        bus(0, sdm_pkg::ADDR_MASK, 0);
        chk("mask", {28'h0, sdm_pkg::MASK_RESET}, rdata);
        cyc(STBY + 4);
        @(negedge clk);
        chk("lowPower", 1, lowPower);
        chk("irq masked", 0, irq);
        bus(1, sdm_pkg::ADDR_MASK, 32'hF);
        @(negedge clk);
        chk("irq", 1, irq);
        bus(0, sdm_pkg::ADDR_IRQ, 0);
        chk("irq status", 32'h1 << sdm_pkg::EV_STANDBY, rdata);
        @(negedge clk);
        chk("irq cleared", 0, irq);
        // diagnostic state: random select and off-state levels through the mux
        @(posedge clk);
        diagnostic_enable <= 1'b1;
        cyc(2);
        bus(0, sdm_pkg::ADDR_STATUS, 0);
        chk("state", sdm_pkg::SDM_ST_DIAG, rdata[3:1]);
        for (i = 0; i < 8; i++) begin
            s = 1'($urandom_range(1, 0));
            o = 1'($urandom_range(1, 0));
            sense_select <= s;
            offStateAbove <= o;
            cyc(2);
            @(negedge clk);
            chk("sense", exp_sns(1, s, o), sense_output);
            @(posedge clk);
        end
        sense_select <= 1'b0;
        offStateAbove <= 1'b1;
        cyc(2);
        enable <= 1'b1;
        cyc(2);
        @(negedge clk);
        chk("switchOn", 1, switchOn);
        chk("sense on", exp_sns(1, 0, 0), sense_output);
        cyc(SETTLE + 6);
        @(negedge clk);
        chk("median", exp_sns(1, 0, 0), median);
        // current limit held by the latch pin
        bus(0, sdm_pkg::ADDR_IRQ, 0);
        currentLimit <= 1'b1;
        latchPin <= 1'b1;
        cyc(2);
        @(negedge clk);
        chk("switch off", 0, switchOn);
        chk("sense fault", exp_sns(1, 0, 1), sense_output);
        @(posedge clk);
        currentLimit <= 1'b0;
        cyc(RETRY + 4);
        @(negedge clk);
        chk("latched", 0, switchOn);
        @(posedge clk);
        latchPin <= 1'b0;
        cyc(3);
        @(negedge clk);
        chk("retry on", 1, switchOn);
        bus(0, sdm_pkg::ADDR_IRQ, 0);
        chk("fault events", 32'h3, rdata & 32'h3);
        // thermal shutdown held by the software latch, enable dropped meanwhile
        bus(1, sdm_pkg::ADDR_CONTROL, 32'h1);
        thermalShutdown <= 1'b1;
        cyc(2);
        enable <= 1'b0;
        thermalShutdown <= 1'b0;
        cyc(RETRY + 4);
        bus(0, sdm_pkg::ADDR_STATUS, 0);
        chk("fault held", sdm_pkg::SDM_ST_FAULT, rdata[3:1]);
        bus(1, sdm_pkg::ADDR_CONTROL, 32'h0);
        cyc(3);
        bus(0, sdm_pkg::ADDR_STATUS, 0);
        chk("exit state", sdm_pkg::SDM_ST_DIAG, rdata[3:1]);
        chk("exit off", 0, rdata[4]);
        // off-state fault shows in the diagnostic state, then a diag fall clears it
        @(negedge clk);
        chk("off fault", exp_sns(1, 0, 1), sense_output);
        @(posedge clk);
        diagnostic_enable <= 1'b0;
        cyc(STBY + RETRY + 6);
        @(negedge clk);
        chk("standby again", 1, lowPower);
        chk("sense off", exp_sns(0, 0, 0), sense_output);
        bus(0, sdm_pkg::ADDR_STATUS, 0);
        chk("off fault cleared", 0, rdata[5]);
        // enable rise wakes the switch straight from standby
        enable <= 1'b1;
        cyc(2);
        @(negedge clk);
        chk("wake", 1, switchOn);
        final_report();
    end
endmodule
`default_nettype wire
